// >>> inc/dms_regs.vh
// constants and rule summary of the diagnostic mode sequencer
// Summary of operation
// - data crc error halts with led code 1000 (error value 200)
// - unrecoverable sector (070,120,130,160,170) shows code 1001
// - lost drive read signal (110) shows code 1010
// - read/write controller failure (220,320,330) shows code 1011
// - master controller out of sync (340) shows code 1100
// - drive failure (010,020,030,050) shows code 1101
// - read-back data differing from written pattern shows code 1110
// - write or write-format failure (270,370) shows code 1111
// - any error except in an alignment routine puts code on leds 5-8, halts, run light off
// - self-tests complete after power-up before selected test starts
// - led 2 lit on self-test error halt, off for routine errors
// - running: leds 5,6 show density, led 8 shows selected drive
// - code 11110 runs self-test, format, reads, writes, density steps
// - after a drive, next drive: format if unformatted, else read
// - switch 8 set alternates drive 1 then 0; clear uses drive 0
// - code 11111 is like 11110 but never write-formats
// - alignment routines never halt on a not-ready drive
// - code 00100 homes, then loads 100 ms, unloads 100 ms forever
// - code 00101 homes, then steps loaded head 01/02 every 70 ms
// - codes 00110..01001 home, seek 01/02/38/76, hold head loaded
// - code 01100 loops controller self-test; failure is 1011, led 2
// - code 01101 counts pll clocks for 50 ms; bad count is 1010
// - switches 1-5 select test, 1 is msb; 1,2,3 zero is normal
// - leds 1,2 off outside self-test; led 3 writing, led 4 reading
`ifndef DMS_REGS_VH
`define DMS_REGS_VH
`define DMS_CLK_MHZ        250
`define DMS_T_HEAD_MS      100
`define DMS_T_STEP_MS      70
`define DMS_T_PLL_MS       50
`define DMS_CYC(ms)        ((ms) * 1000 * `DMS_CLK_MHZ)
`define DMS_PLL_MIN        32'h0000_1000
`define DMS_PLL_MAX        32'h0010_0000
// test selector codes
`define DMS_T_HEADLOAD     5'h04
`define DMS_T_TRK0ADJ      5'h05
`define DMS_T_SEEK01       5'h06
`define DMS_T_SEEK02       5'h07
`define DMS_T_SEEK38       5'h08
`define DMS_T_SEEK76       5'h09
`define DMS_T_RWCTL        5'h0c
`define DMS_T_PLL          5'h0d
`define DMS_T_EXFMT        5'h1e
`define DMS_T_EXER         5'h1f
// error register values (octal)
`define DMS_E_HOME0        9'o010
`define DMS_E_HOME1        9'o020
`define DMS_E_TRK0IN       9'o030
`define DMS_E_TRK0         9'o050
`define DMS_E_NOSEC        9'o070
`define DMS_E_NORD         9'o110
`define DMS_E_NOPRE        9'o120
`define DMS_E_NOIDAM       9'o130
`define DMS_E_TRIES        9'o160
`define DMS_E_NODAM        9'o170
`define DMS_E_DCRC         9'o200
`define DMS_E_RWST         9'o220
`define DMS_E_WFMT         9'o270
`define DMS_E_RWWR         9'o320
`define DMS_E_RWTO         9'o330
`define DMS_E_SYNC         9'o340
`define DMS_E_ACLO         9'o370
// led error codes
`define DMS_L_NONE         4'h0
`define DMS_L_DCRC         4'h8
`define DMS_L_SECT         4'h9
`define DMS_L_RDLOST       4'ha
`define DMS_L_RWCTL        4'hb
`define DMS_L_MASTER       4'hc
`define DMS_L_DRIVE        4'hd
`define DMS_L_PATTERN      4'he
`define DMS_L_WRITE        4'hf
// operation codes towards the drive engine
`define DMS_OP_SELFTEST    4'h1
`define DMS_OP_FORMAT      4'h2
`define DMS_OP_SEQRD       4'h3
`define DMS_OP_WRRD        4'h4
`define DMS_OP_BFLYRD      4'h5
`define DMS_OP_SETDD       4'h6
`define DMS_OP_SETSD       4'h7
`define DMS_OP_HOME        4'h8
`define DMS_OP_SEEK        4'h9
`define DMS_OP_RWTEST      4'ha
`define DMS_OP_NONE        4'h0
`endif

// >>> logic/dms_err_map.v
// error register value to led code translation
`include "dms_regs.vh"
module dms_err_map (
   input  wire [8:0] err_value,   // error register value
   input  wire       pat_err,     // pattern compare mismatch
   output reg  [3:0] led_code     // code for leds 5-8
);
   always @* begin
      if (pat_err) begin
         led_code = `DMS_L_PATTERN;
      end else begin
         case (err_value)
            `DMS_E_DCRC:  led_code = `DMS_L_DCRC;
            `DMS_E_NOSEC, `DMS_E_NOPRE, `DMS_E_NOIDAM,
            `DMS_E_TRIES, `DMS_E_NODAM:
                          led_code = `DMS_L_SECT;
            `DMS_E_NORD:  led_code = `DMS_L_RDLOST;
            `DMS_E_RWST, `DMS_E_RWWR, `DMS_E_RWTO:
                          led_code = `DMS_L_RWCTL;
            `DMS_E_SYNC:  led_code = `DMS_L_MASTER;
            `DMS_E_HOME0, `DMS_E_HOME1, `DMS_E_TRK0IN,
            `DMS_E_TRK0:  led_code = `DMS_L_DRIVE;
            `DMS_E_WFMT, `DMS_E_ACLO:
                          led_code = `DMS_L_WRITE;
            default:      led_code = `DMS_L_NONE;
         endcase
      end
   end
endmodule // dms_err_map

// >>> logic/dms_timer.v
// one-shot cycle timer, done pulses when the count expires
`include "dms_regs.vh"
module dms_timer (
   input  wire        clock,      // system clock
   input  wire        sys_rst,    // synchronous reset
   input  wire        start,      // load and begin counting
   input  wire [31:0] load,       // cycles to count
   output wire        done,       // one-cycle pulse at expiry
   output wire [31:0] elapsed     // cycles counted since start
);
   reg [31:0] cnt_q;
   reg [31:0] el_q;
   reg        run_q;
   assign done    = run_q && (cnt_q == 32'h0000_0001);
   assign elapsed = el_q;
   always @(posedge clock) begin
      if (sys_rst) begin
         cnt_q <= 32'h0000_0000;
         el_q  <= 32'h0000_0000;
         run_q <= 1'b0;
      end else if (start) begin
         cnt_q <= load;
         el_q  <= 32'h0000_0000;
         run_q <= 1'b1;
      end else if (run_q) begin
         cnt_q <= cnt_q - 32'h0000_0001;
         el_q  <= el_q + 32'h0000_0001;
         if (cnt_q == 32'h0000_0001) begin
            run_q <= 1'b0;
         end
      end
   end
endmodule // dms_timer

// >>> logic/dms_sequencer.v
// stand-alone diagnostic sequencer: test selection, steps, leds, halt
`include "dms_regs.vh"
module dms_sequencer #(
   parameter [31:0] HEAD_CYC = `DMS_CYC(`DMS_T_HEAD_MS), // head load time
   parameter [31:0] STEP_CYC = `DMS_CYC(`DMS_T_STEP_MS), // step period
   parameter [31:0] PLL_CYC  = `DMS_CYC(`DMS_T_PLL_MS),  // pll window
   parameter [31:0] PLL_MIN  = `DMS_PLL_MIN,             // lower pll limit
   parameter [31:0] PLL_MAX  = `DMS_PLL_MAX              // upper pll limit
) (
   input  wire        clock,        // system clock, 250 MHz
   input  wire        sys_rst,      // synchronous power-up reset
   input  wire [7:0]  switches,     // dip switches, [7] is switch 1
   output wire        normal_mode,  // switches 1-3 zero: normal operation
   output reg         op_start,     // pulse: start operation on engine
   output reg  [3:0]  op_code,      // operation for the engine
   output reg         op_drive,     // drive for the operation
   output reg  [6:0]  op_track,     // seek target track
   input  wire        op_done,      // engine pulse: operation finished
   input  wire        op_error,     // engine pulse: operation failed
   input  wire [8:0]  error_code_register, // error value with op_error
   input  wire        pat_mismatch, // with op_error: compare failed
   input  wire        drive_ready,  // selected drive ready
   input  wire [1:0]  density,      // 01 single, 10 double, else unknown
   input  wire        writing,      // engine is writing the diskette
   input  wire        reading,      // engine is reading the diskette
   input  wire        pll_clk_tick, // one pulse per pll clock cycle
   output reg         head_load,    // head load request to drive
   output wire [7:0]  leds,         // leds 1..8, [7] is led 1
   output wire        run_led       // run indicator
);
   ////////////////////////////////////////////////////////////////////////
   localparam [3:0] S_IDLE   = 4'h0;
   localparam [3:0] S_SELF   = 4'h1;
   localparam [3:0] S_DISP   = 4'h2;
   localparam [3:0] S_EXSTEP = 4'h3;
   localparam [3:0] S_EXWAIT = 4'h4;
   localparam [3:0] S_HOME   = 4'h5;
   localparam [3:0] S_SEEK   = 4'h6;
   localparam [3:0] S_HLOAD  = 4'h7;
   localparam [3:0] S_STEP   = 4'h8;
   localparam [3:0] S_HOLD   = 4'h9;
   localparam [3:0] S_RWTEST = 4'ha;
   localparam [3:0] S_PLL    = 4'hb;
   localparam [3:0] S_HALT   = 4'hc;
   localparam [3:0] S_NORMAL = 4'hd;

   reg  [3:0]  state_q, state_d;
   reg  [3:0]  step_q;         // exerciser step, 1..10 as listed
   reg  [1:0]  fmt_q;          // per-drive formatted flags
   reg  [4:0]  test_q;         // test code latched after reset
   reg         sw8_q;
   reg         drive_q;
   reg         busy_q;         // self-test or exerciser operation issued, waiting for engine
   reg         self_q;         // running hardware self-test
   reg         halt_q;
   reg         halt_self_q;    // halt came from self-test
   reg  [3:0]  code_q;
   reg         phase_q;        // step target, set for track 01, clear for 02
   reg  [31:0] pll_cnt_q;
   reg         tmr_start;
   reg  [31:0] tmr_load;
   wire        tmr_done;
   wire [3:0]  map_code;
   wire        align;

   assign normal_mode = (switches[7:5] == 3'b000);
   assign align = (test_q >= `DMS_T_HEADLOAD) &&
                  (test_q <= `DMS_T_SEEK76);

   dms_err_map u_map (
      .err_value (error_code_register),
      .pat_err   (pat_mismatch),
      .led_code  (map_code)
   );

   dms_timer u_tmr (
      .clock   (clock),
      .sys_rst (sys_rst),
      .start   (tmr_start),
      .load    (tmr_load),
      .done    (tmr_done),
      .elapsed ()
   );

   ////////////////////////////////////////////////////////////////////////
   // leds: error code on halt, density and drive while running
   assign run_led = !halt_q;
   assign leds[7] = self_q && !halt_q;
   assign leds[6] = halt_q ? halt_self_q : self_q;
   assign leds[5] = writing && !halt_q;
   assign leds[4] = reading && !halt_q;
   assign leds[3:0] = halt_q ? code_q :
                      {density[1], density[0], 1'b0, drive_q};

   // exerciser step to operation, steps numbered as in the sequence
   function [3:0] ex_op;
      input [3:0] s;
      begin
         case (s)
            4'h1:    ex_op = `DMS_OP_SELFTEST;
            4'h2:    ex_op = `DMS_OP_FORMAT;
            4'h3:    ex_op = `DMS_OP_SEQRD;
            4'h4:    ex_op = `DMS_OP_WRRD;
            4'h5:    ex_op = `DMS_OP_BFLYRD;
            4'h6:    ex_op = `DMS_OP_SETDD;
            4'h7:    ex_op = `DMS_OP_SEQRD;
            4'h8:    ex_op = `DMS_OP_WRRD;
            4'h9:    ex_op = `DMS_OP_BFLYRD;
            4'ha:    ex_op = `DMS_OP_SETSD;
            default: ex_op = `DMS_OP_NONE;
         endcase
      end
   endfunction

   function [6:0] seek_trk;
      input [4:0] t;
      begin
         case (t)
            `DMS_T_SEEK01: seek_trk = 7'd1;
            `DMS_T_SEEK02: seek_trk = 7'd2;
            `DMS_T_SEEK38: seek_trk = 7'd38;
            `DMS_T_SEEK76: seek_trk = 7'd76;
            default:       seek_trk = 7'd0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      state_d = state_q;
      case (state_q)
         S_IDLE:   state_d = S_SELF;
         S_SELF:   if (op_done) state_d = S_DISP;
         S_DISP: begin
            if (test_q[4:2] == 3'b000)
               state_d = S_NORMAL;
            else if (test_q == `DMS_T_EXFMT || test_q == `DMS_T_EXER)
               state_d = S_EXSTEP;
            else if (align)
               state_d = S_HOME;
            else if (test_q == `DMS_T_RWCTL)
               state_d = S_RWTEST;
            else if (test_q == `DMS_T_PLL)
               state_d = S_PLL;
            else
               state_d = S_HOLD;
         end
         S_EXSTEP: state_d = S_EXWAIT;
         S_EXWAIT: if (op_done) state_d = S_EXSTEP;
         S_HOME:   if (op_done) state_d = (test_q == `DMS_T_HEADLOAD) ?
                                          S_HLOAD :
                                          (test_q == `DMS_T_TRK0ADJ) ?
                                          S_STEP : S_SEEK;
         S_SEEK:   if (op_done) state_d = S_HOLD;
         S_HLOAD:  state_d = S_HLOAD;
         S_STEP:   state_d = S_STEP;
         S_RWTEST: state_d = S_RWTEST;
         S_PLL:    state_d = S_PLL;
         S_HOLD:   state_d = S_HOLD;
         S_HALT:   state_d = S_HALT;
         S_NORMAL: state_d = S_NORMAL;
         default:  state_d = S_IDLE;
      endcase
      if (op_error && state_q != S_HALT && state_q != S_NORMAL &&
          !(align && state_q != S_SELF))
         state_d = S_HALT;
      if (state_q == S_PLL && tmr_done &&
          (pll_cnt_q < PLL_MIN || pll_cnt_q > PLL_MAX))
         state_d = S_HALT;
   end

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      if (sys_rst) begin
         state_q     <= S_IDLE;
         step_q      <= 4'h0;
         fmt_q       <= 2'b00;
         test_q      <= 5'h00;
         sw8_q       <= 1'b0;
         drive_q     <= 1'b0;
         busy_q      <= 1'b0;
         self_q      <= 1'b0;
         halt_q      <= 1'b0;
         halt_self_q <= 1'b0;
         code_q      <= `DMS_L_NONE;
         phase_q     <= 1'b0;
         pll_cnt_q   <= 32'h0000_0000;
         op_start    <= 1'b0;
         op_code     <= `DMS_OP_NONE;
         op_drive    <= 1'b0;
         op_track    <= 7'd0;
         head_load   <= 1'b0;
         tmr_start   <= 1'b0;
         tmr_load    <= 32'h0000_0000;
      end else begin
         state_q   <= state_d;
         op_start  <= 1'b0;
         tmr_start <= 1'b0;
         if (op_done || op_error)
            busy_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               // switches are caught after reset release, not at reset
               test_q   <= switches[7:3];
               sw8_q    <= switches[0];
               drive_q  <= switches[0];
               op_start <= 1'b1;
               op_code  <= `DMS_OP_SELFTEST;
               self_q   <= 1'b1;
               busy_q   <= 1'b1;
            end
            S_SELF: if (op_done) begin
               self_q <= 1'b0;
               step_q <= (test_q == `DMS_T_EXFMT) ? 4'h2 : 4'h3;
            end
            S_EXSTEP: begin
               op_start <= 1'b1;
               op_code  <= ex_op(step_q);
               op_drive <= drive_q;
               self_q   <= (step_q == 4'h1);
               busy_q   <= 1'b1;
            end
            S_EXWAIT: if (op_done) begin
               self_q <= 1'b0;
               if (step_q == 4'h2)
                  fmt_q[drive_q] <= 1'b1;
               if (step_q == 4'ha) begin
                  drive_q <= sw8_q ? !drive_q : 1'b0;
                  if (test_q == `DMS_T_EXFMT &&
                      !fmt_q[sw8_q ? !drive_q : 1'b0])
                     step_q <= 4'h2;
                  else
                     step_q <= 4'h3;
               end else begin
                  step_q <= step_q + 4'h1;
               end
            end
            S_DISP: begin
               if (align) begin
                  op_start <= 1'b1;
                  op_code  <= `DMS_OP_HOME;
                  op_drive <= drive_q;
               end else if (test_q == `DMS_T_RWCTL) begin
                  op_start <= 1'b1;
                  op_code  <= `DMS_OP_RWTEST;
                  self_q   <= 1'b1;
               end else if (test_q == `DMS_T_PLL) begin
                  tmr_start <= 1'b1;
                  tmr_load  <= PLL_CYC;
                  pll_cnt_q <= 32'h0000_0000;
               end
            end
            S_HOME: if (op_done) begin
               head_load <= 1'b1;
               phase_q   <= 1'b1;
               tmr_start <= 1'b1;
               if (test_q == `DMS_T_HEADLOAD)
                  tmr_load <= HEAD_CYC;
               else
                  tmr_load <= STEP_CYC;
               if (test_q != `DMS_T_HEADLOAD &&
                   test_q != `DMS_T_TRK0ADJ) begin
                  op_start <= 1'b1;
                  op_code  <= `DMS_OP_SEEK;
                  op_track <= seek_trk(test_q);
               end
            end
            S_HLOAD: if (tmr_done) begin
               head_load <= !head_load;
               tmr_start <= 1'b1;
               tmr_load  <= HEAD_CYC;
            end
            S_STEP: if (tmr_done) begin
               // loaded head alternates between tracks 01 and 02
               op_start  <= 1'b1;
               op_code   <= `DMS_OP_SEEK;
               op_track  <= phase_q ? 7'd1 : 7'd2;
               phase_q   <= !phase_q;
               tmr_start <= 1'b1;
               tmr_load  <= STEP_CYC;
            end
            S_RWTEST: if (op_done) begin
               op_start <= 1'b1;
               op_code  <= `DMS_OP_RWTEST;
            end
            S_PLL: begin
               if (pll_clk_tick)
                  pll_cnt_q <= pll_cnt_q + 32'h0000_0001;
               if (tmr_done) begin
                  pll_cnt_q <= 32'h0000_0000;
                  tmr_start <= 1'b1;
                  tmr_load  <= PLL_CYC;
               end
            end
            default: ;
         endcase
         if (state_d == S_HALT && state_q != S_HALT) begin
            halt_q    <= 1'b1;
            head_load <= 1'b0;
            if (state_q == S_PLL)
               code_q <= `DMS_L_RDLOST;
            else if (state_q == S_RWTEST)
               code_q <= `DMS_L_RWCTL;
            else
               code_q <= map_code;
            halt_self_q <= self_q || state_q == S_RWTEST;
         end
      end
   end
endmodule // dms_sequencer

// >>> testbench/dms_sequencer_sva.sv
// port assertions for the diagnostic mode sequencer
`include "dms_regs.vh"
module dms_sequencer_sva (
   input wire       clock,        // clock
   input wire       sys_rst,      // reset
   input wire [7:0] switches,     // switches
   input wire       normal_mode,  // normal mode
   input wire       op_start,     // op start
   input wire [3:0] op_code,      // op code
   input wire       op_drive,     // op drive
   input wire       op_done,      // op done
   input wire       op_error,     // op error
   input wire [8:0] error_code_register, // error value
   input wire       pat_mismatch, // pattern flag
   input wire [7:0] leds,         // leds
   input wire       run_led       // run light
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   wire [4:0] sel   = switches[7:3];
   wire       exer  = sel[4:1] == 4'hf;
   wire       align = sel >= 5'h04 && sel <= 5'h09;
   reg  [3:0] code_q;
   // expected code is held one cycle, where the halt display lands
   always @(posedge clock) begin
      if (pat_mismatch)
         code_q <= 4'he;
      else case (error_code_register)
         `DMS_E_DCRC: code_q <= 4'h8;
         `DMS_E_NOSEC, `DMS_E_NOPRE, `DMS_E_NOIDAM, `DMS_E_TRIES,
         `DMS_E_NODAM: code_q <= 4'h9;
         `DMS_E_NORD: code_q <= 4'ha;
         `DMS_E_RWST, `DMS_E_RWWR, `DMS_E_RWTO: code_q <= 4'hb;
         `DMS_E_SYNC: code_q <= 4'hc;
         `DMS_E_HOME0, `DMS_E_HOME1, `DMS_E_TRK0IN,
         `DMS_E_TRK0: code_q <= 4'hd;
         `DMS_E_WFMT, `DMS_E_ACLO: code_q <= 4'hf;
         default: code_q <= 4'h0;
      endcase
   end
   a_normal_sel: assert property (normal_mode == (switches[7:5] == 3'b000))
      else $error("normal mode does not follow switches 1 to 3");
   a_boot_selftest: assert property ($fell(sys_rst) |-> ##[0:2] (op_start && op_code == 4'h1))
      else $error("no self-test request after reset");
   a_err_code: assert property (exer && run_led && op_error |=> !run_led && leds[3:0] == code_q)
      else $error("wrong halt code on error");
   a_halt_holds: assert property (!run_led |=> !run_led && $stable(leds[3:0]))
      else $error("halt display did not stand");
   a_led2_self: assert property (exer && run_led && op_error && op_code == 4'h1 |=> leds[6])
      else $error("led 2 off after self-test error");
   a_led2_routine: assert property (exer && run_led && op_error && op_code != 4'h1 |=> !leds[6])
      else $error("led 2 on after routine error");
   a_align_run: assert property (align && run_led && op_error && op_code != 4'h1 |=> run_led)
      else $error("alignment routine halted");
   a_fmt_first: assert property (sel == 5'h1e && run_led && op_done && op_code == 4'h1 |-> ##3 op_start && op_code == 4'h2 && op_drive == switches[0])
      else $error("exerciser did not start with format");
   a_skip_fmt: assert property (sel == 5'h1f && run_led && op_done && op_code == 4'h1 |-> ##3 op_start && op_code == 4'h3 && op_drive == switches[0])
      else $error("exerciser did not start with read");
endmodule // dms_sequencer_sva
bind dms_sequencer dms_sequencer_sva dms_sequencer_sva_inst (
   .clock(clock), .sys_rst(sys_rst), .switches(switches),
   .normal_mode(normal_mode), .op_start(op_start), .op_code(op_code),
   .op_drive(op_drive), .op_done(op_done), .op_error(op_error),
   .error_code_register(error_code_register),
   .pat_mismatch(pat_mismatch), .leds(leds), .run_led(run_led));

// >>> testbench/dms_engine_model.sv
// drive engine model answering operation requests of the sequencer
module dms_engine_model (
   input  wire       clock,    // clock
   input  wire       sys_rst,  // reset
   input  wire       op_start, // request pulse
   input  wire [3:0] op_code,  // requested operation
   input  wire [3:0] fail_op,  // operation made to fail
   input  wire [8:0] fail_val, // error value to report
   input  wire       fail_pat, // report pattern mismatch
   output reg        op_done,  // finish pulse
   output reg        op_error, // failure pulse
   output reg  [8:0] err_val,  // error value
   output reg        pat_err,  // pattern flag
   output wire       writing,  // write activity
   output wire       reading   // read activity
);
   timeunit 1ns;
   timeprecision 100ps;
   reg [2:0] cnt_q;
   reg [3:0] code_q;
   wire      busy = cnt_q != 3'h0;
   assign writing = busy && (code_q == 4'h2 || code_q == 4'h4);
   assign reading = busy && (code_q == 4'h3 || code_q == 4'h5);
   always @(posedge clock) begin
      op_done <= 1'b0;
      op_error <= 1'b0;
      pat_err <= 1'b0;
      // outside a failure the value keeps moving, never a stale match
      err_val <= ~err_val;
      if (sys_rst) begin
         cnt_q <= 3'h0;
         err_val <= 9'h000;
      end else if (op_start) begin
         cnt_q <= 3'h3;
         code_q <= op_code;
      end else if (cnt_q == 3'h1) begin
         cnt_q <= 3'h0;
         op_error <= code_q == fail_op;
         op_done <= code_q != fail_op;
         if (code_q == fail_op) begin
            err_val <= fail_val;
            pat_err <= fail_pat;
         end
      end else if (busy) begin
         cnt_q <= cnt_q - 3'h1;
      end
   end
endmodule // dms_engine_model

// >>> testbench/testbench.sv
// self-checking bench for the diagnostic mode sequencer
`include "dms_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  switches = 8'h00;
   logic [3:0]  fail_op = 4'h0;
   logic [8:0]  fail_val = 9'h000;
   logic        fail_pat = 1'b0;
   logic [1:0]  density = 2'b01;
   logic        pll_clk_tick = 1'b0;
   wire         normal_mode, op_start, op_drive, op_done, op_error;
   wire         pat_mismatch, writing, reading, head_load, run_led;
   wire  [3:0]  op_code;
   wire  [6:0]  op_track;
   wire  [8:0]  error_code_register;
   wire  [7:0]  leds;
   int          err_count = 0;
   int          comparisons = 0;
   logic [13:0] tbl [18];
   dms_sequencer #(.HEAD_CYC(32'd20), .STEP_CYC(32'd20),
      .PLL_CYC(32'd20)) dms_sequencer_inst (
      .clock(clock), .sys_rst(sys_rst), .switches(switches),
      .normal_mode(normal_mode), .op_start(op_start), .op_code(op_code),
      .op_drive(op_drive), .op_track(op_track), .op_done(op_done),
      .op_error(op_error), .error_code_register(error_code_register),
      .pat_mismatch(pat_mismatch), .drive_ready(1'b1),
      .density(density), .writing(writing), .reading(reading),
      .pll_clk_tick(pll_clk_tick), .head_load(head_load), .leds(leds),
      .run_led(run_led));
   dms_engine_model dms_engine_model_inst (
      .clock(clock), .sys_rst(sys_rst), .op_start(op_start),
      .op_code(op_code), .fail_op(fail_op), .fail_val(fail_val),
      .fail_pat(fail_pat), .op_done(op_done), .op_error(op_error),
      .err_val(error_code_register), .pat_err(pat_mismatch),
      .writing(writing), .reading(reading));
   initial forever #2 clock = ~clock;
   initial begin
      #40000 err_count++;
      stop_test();
   end
   //////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (err_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic step(); @(posedge clock); #1; endtask
   task automatic boot(logic [7:0] sw);
      step();
      sys_rst = 1'b1;
      switches = sw;
      repeat (3) @(posedge clock);
      #1 sys_rst = 1'b0;
   endtask
   task automatic wait_op(logic [3:0] code, logic any_drv, logic drv);
      int n;
      n = 0;
      while (!(op_start === 1'b1 && (any_drv ? op_code === code
             : op_drive === drv)) && n < 400) begin
         step();
         n++;
      end
      chk("op_seen", 1, n < 400);
   endtask
   task automatic t_exer(logic [7:0] sw, logic [3:0] exp);
      fail_op = 4'h0;
      boot(sw);
      wait_op(4'h1, 1, 0);
      chk("self_led", 1, leds[7]);
      wait_op(exp, 1, 0);
      chk("op_drive", sw[0], op_drive);
      repeat (2) step();
      chk("density_leds", density, leds[3:2]);
      chk("drive_led", sw[0], leds[0]);
      chk("rw_leds", {2'b00, exp == 4'h2, exp == 4'h3}, leds[7:4]);
   endtask
   task automatic t_err(logic [7:0] sw, logic [3:0] fop, logic [13:0] e,
                        logic l2);
      int n;
      fail_op = fop;
      fail_val = e[13:5];
      fail_pat = e[4];
      boot(sw);
      n = 0;
      while (run_led !== 1'b0 && n < 400) begin
         step();
         n++;
      end
      chk("halt", 0, run_led);
      chk("err_leds", e[3:0], leds[3:0]);
      chk("led2", l2, leds[6]);
   endtask
   task automatic t_align(logic [4:0] c, logic [6:0] trk);
      fail_op = 4'h9;
      fail_val = `DMS_E_HOME0;
      boot({c, 3'b000});
      wait_op(4'h8, 1, 0);
      wait_op(4'h9, 1, 0);
      chk("op_track", trk, op_track);
      repeat (10) step();
      chk("align_run", 1, run_led);
      chk("head_held", 1, head_load);
   endtask
   task automatic t_head();
      int n;
      fail_op = 4'h0;
      boot(8'h20);
      wait_op(4'h8, 1, 0);
      for (int k = 0; k < 3; k++) begin
         n = 0;
         while (head_load === logic'(k[0]) && n < 400) begin
            step();
            n++;
         end
         if (k > 0) chk("head_phase", 1, n >= 19 && n <= 21);
      end
   endtask
   initial begin
      tbl = '{{`DMS_E_DCRC, 5'h08}, {`DMS_E_NOSEC, 5'h09},
         {`DMS_E_NOPRE, 5'h09}, {`DMS_E_NOIDAM, 5'h09},
         {`DMS_E_TRIES, 5'h09}, {`DMS_E_NODAM, 5'h09},
         {`DMS_E_NORD, 5'h0a}, {`DMS_E_RWST, 5'h0b},
         {`DMS_E_RWWR, 5'h0b}, {`DMS_E_RWTO, 5'h0b},
         {`DMS_E_SYNC, 5'h0c}, {`DMS_E_HOME0, 5'h0d},
         {`DMS_E_HOME1, 5'h0d}, {`DMS_E_TRK0IN, 5'h0d},
         {`DMS_E_TRK0, 5'h0d}, {9'h000, 5'h1e},
         {`DMS_E_WFMT, 5'h0f}, {`DMS_E_ACLO, 5'h0f}};
      #1 switches = 8'h1f;
      #1 chk("normal_mode", 1, normal_mode);
      switches = 8'h20;
      #1 chk("normal_mode", 0, normal_mode);
      t_exer(8'hf1, 4'h2);
      wait_op(4'h0, 0, 0);
      chk("next_fmt", 4'h2, op_code);
      wait_op(4'h0, 0, 1);
      chk("next_read", 4'h3, op_code);
      density = 2'b10;
      t_exer(8'hf8, 4'h3);
      t_err(8'hf8, 4'h1, {`DMS_E_RWST, 5'h0b}, 1'b1);
      foreach (tbl[i]) t_err(8'hf8, 4'h3, tbl[i], 1'b0);
      t_err(8'h60, 4'ha, {9'h000, 5'h0b}, 1'b1);
      pll_clk_tick = 1'b1;
      t_err(8'h68, 4'h0, {9'h000, 5'h0a}, 1'b0);
      t_align(5'h05, 7'd1);
      t_align(5'h06, 7'd1);
      t_align(5'h07, 7'd2);
      t_align(5'h08, 7'd38);
      t_align(5'h09, 7'd76);
      t_head();
      stop_test();
   end
endmodule // testbench
